// >>> rtl/uei_pkg.sv
// Constants for the UART event interrupt enable block.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
package uei_pkg;

  // Register byte offsets.
  localparam logic [11:0] UEI_ADDR_MASK = 12'h300;
  localparam logic [11:0] UEI_ADDR_SET = 12'h304;
  localparam logic [11:0] UEI_ADDR_CLR = 12'h308;

  // Bus geometry.
  localparam int UEI_ADDR_W = 12;
  localparam int UEI_DATA_W = 32;
  localparam int UEI_BE_W = 4;

  // Event bit positions inside every enable register.
  localparam int UEI_BIT_CTS = 0;
  localparam int UEI_BIT_CTS_OFF = 1;
  localparam int UEI_BIT_RXRDY = 2;
  localparam int UEI_BIT_RXEND = 3;
  localparam int UEI_BIT_TXSENT = 4;
  localparam int UEI_BIT_TXEND = 5;
  localparam int UEI_BIT_ERROR = 6;
  localparam int UEI_BIT_RX_TIMEOUT = 7;
  localparam int UEI_BIT_RXBEGUN = 8;
  localparam int UEI_BIT_TXBEGUN = 9;
  localparam int UEI_BIT_TXHALT = 10;
  localparam int UEI_NUM_EVT = 11;

  // Reset values.
  localparam logic [UEI_NUM_EVT-1:0] UEI_EN_RST = 11'h000;
  localparam logic [UEI_DATA_W-1:0] UEI_DATA_RST = 32'h0000_0000;

  // Bus answer latency in cycles: one wait state per access.
  localparam int UEI_WAIT_CYC = 1;

endpackage : uei_pkg

// >>> rtl/uei_top.sv
// UART event interrupt enable: enable register, set and clear aliases,
// and the gated interrupt output.
// Assumes event flags come from logic on clk_sys and an Avalon-MM master.
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/10ps

// Contract
// - Read/write enable register at 0x300, all bits reset to zero.
// - Clear-to-send enable bit: 0 blocks, 1 allows its interrupt.
// - Clear-to-send-deasserted enable bit: 0 blocks, 1 allows.
// - Received-byte-ready enable bit: 0 blocks, 1 allows.
// - Receive-buffer-end enable bit: 0 blocks, 1 allows.
// - Transmitted-byte enable bit: 0 blocks, 1 allows.
// - Transmit-buffer-end enable bit: 0 blocks, 1 allows.
// - Error-detected enable bit: 0 blocks, 1 allows.
// - Receiver-timeout enable bit: 0 blocks, 1 allows.
// - Receiver-started enable bit: 0 blocks, 1 allows.
// - Transmitter-started enable bit: 0 blocks, 1 allows.
// - Transmitter-stopped enable bit: 0 blocks, 1 allows.
// - Set alias at 0x304: writing 1 turns that enable on.
// - Reading the set alias returns the current enable bits.
// - Clear alias at 0x308: writing 1 turns off; reads return enables.
module uei_top
  import uei_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_b,
  // Avalon-MM slave.
  input wire logic [uei_pkg::UEI_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [uei_pkg::UEI_DATA_W-1:0] avs_writedata,
  input wire logic [uei_pkg::UEI_BE_W-1:0] avs_byteenable,
  output logic [uei_pkg::UEI_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Event flags and interrupt.
  input wire logic [uei_pkg::UEI_NUM_EVT-1:0] evt_flags,
  output logic uart_irq
);
  import uei_pkg::*;

  typedef struct packed {
    logic [UEI_NUM_EVT-1:0] en;
    logic ack;
    logic [UEI_DATA_W-1:0] rdata;
    logic irq;
  } uei_state_t;

  uei_state_t st_q;
  uei_state_t st_d;
  logic req;
  logic acc_wr;
  logic acc_rd;
  logic [UEI_DATA_W-1:0] lane_mask;
  logic [UEI_DATA_W-1:0] wmask;
  logic [UEI_NUM_EVT-1:0] wbits;
  logic [UEI_NUM_EVT-1:0] bmask;
  logic [UEI_NUM_EVT-1:0] gated;
  logic hit;

  assign req = avs_read | avs_write;
  // The request is accepted on the edge after its wait state, in the cycle where ack is high.
  assign acc_wr = avs_write & st_q.ack;
  assign acc_rd = avs_read & st_q.ack;
  assign avs_waitrequest = req & ~st_q.ack;
  assign avs_readdata = st_q.rdata;
  assign uart_irq = st_q.irq;

  always_comb begin
    for (int i = 0; i < UEI_BE_W; i++) begin
      lane_mask[i*8 +: 8] = {8{avs_byteenable[i]}};
    end
  end

  assign wmask = avs_writedata & lane_mask;
  assign wbits = wmask[UEI_NUM_EVT-1:0];
  assign bmask = lane_mask[UEI_NUM_EVT-1:0];
  assign hit = (avs_address == UEI_ADDR_MASK) |
               (avs_address == UEI_ADDR_SET) |
               (avs_address == UEI_ADDR_CLR);

  assign gated = evt_flags & st_q.en;

  always_comb begin
    st_d = st_q;
    // Ack rises for exactly one cycle after a wait state, then drops.
    st_d.ack = req & ~st_q.ack;
    st_d.irq = |gated;
    if (acc_wr) begin
      unique case (avs_address)
        UEI_ADDR_MASK: st_d.en = (st_q.en & ~bmask) | wbits;
        UEI_ADDR_SET: st_d.en = st_q.en | wbits;
        UEI_ADDR_CLR: st_d.en = st_q.en & ~wbits;
        default: st_d.en = st_q.en;
      endcase
    end
    // Read data is loaded on the wait edge and held until the next access.
    if (req & ~st_q.ack) begin
      st_d.rdata = UEI_DATA_RST;
      if (avs_read & hit) begin
        st_d.rdata[UEI_NUM_EVT-1:0] = st_q.en;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '{en: UEI_EN_RST, ack: 1'b0, rdata: UEI_DATA_RST, irq: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // Helper: upper read bits must always be zero.
  logic [UEI_DATA_W-1:0] hi_mask;
  assign hi_mask = ~{{(UEI_DATA_W-UEI_NUM_EVT){1'b0}}, {UEI_NUM_EVT{1'b1}}};

  // Helper: bit i is set when no enabled flag other than bit i is raised.
  logic [UEI_NUM_EVT-1:0] solo_evt;
  always_comb begin
    for (int i = 0; i < UEI_NUM_EVT; i++) begin
      solo_evt[i] = (gated & ~({{(UEI_NUM_EVT-1){1'b0}}, 1'b1} << i)) == '0;
    end
  end

  // Register bus and readback checks.
  // direct write
  mask_write_a: assert property (
    acc_wr && avs_address == UEI_ADDR_MASK && (&avs_byteenable)
    |=> st_q.en == $past(avs_writedata[UEI_NUM_EVT-1:0]))
    else $error("Enable register write not stored.");

  set_write_a: assert property (
    acc_wr && avs_address == UEI_ADDR_SET
    |=> (st_q.en & $past(wbits)) == $past(wbits))
    else $error("Set alias did not turn enables on.");

  set_zero_a: assert property (
    acc_wr && avs_address == UEI_ADDR_SET
    |=> (st_q.en & ~$past(wbits)) == ($past(st_q.en) & ~$past(wbits)))
    else $error("Set alias zero bits changed enables.");

  clr_write_a: assert property (
    acc_wr && avs_address == UEI_ADDR_CLR
    |=> (st_q.en & $past(wbits)) == '0 &&
        (st_q.en & ~$past(wbits)) == ($past(st_q.en) & ~$past(wbits)))
    else $error("Clear alias did not act as expected.");

  alias_read_a: assert property (
    avs_read && !avs_waitrequest &&
    (avs_address == UEI_ADDR_SET || avs_address == UEI_ADDR_CLR ||
     avs_address == UEI_ADDR_MASK)
    |-> avs_readdata[UEI_NUM_EVT-1:0] == st_q.en &&
        (avs_readdata & hi_mask) == '0)
    else $error("Readback differs from enable state.");

  shared_en_a: assert property (
    !acc_wr |=> st_q.en == $past(st_q.en))
    else $error("Enables changed without a register write.");

  irq_gate_a: assert property (
    ##1 uart_irq == |($past(evt_flags) & $past(st_q.en)))
    else $error("Interrupt does not follow enabled flags.");

  irq_block_a: assert property (
    st_q.en == '0 [*2] |-> !uart_irq)
    else $error("Interrupt raised with all enables off.");

  // The answer comes after exactly one wait state.
  bus_wait_a: assert property (
    req && !st_q.ack |-> avs_waitrequest ##1 (!req || !avs_waitrequest))
    else $error("Bus answer not given after one wait state.");

  // Unmapped reads return zero.
  unmapped_a: assert property (
    acc_rd && !hit |-> avs_readdata == '0)
    else $error("Unmapped read returned nonzero data.");

  mask_lanes_a: assert property (
    acc_wr && avs_address == UEI_ADDR_MASK && avs_byteenable[1:0] == 2'b00
    |=> st_q.en == $past(st_q.en))
    else $error("Enable register changed under disabled lanes.");

  unmapped_wr_a: assert property (
    acc_wr && !hit |=> st_q.en == $past(st_q.en))
    else $error("Unmapped write changed the enables.");

  rd_keep_a: assert property (
    acc_rd |=> st_q.en == $past(st_q.en))
    else $error("A read changed the enables.");

  rdata_hold_a: assert property (
    !(req && !st_q.ack) |=> $stable(avs_readdata))
    else $error("Read data changed outside a wait state.");

  // Waitrequest stays low for one cycle only.
  wait_once_a: assert property (
    req && !avs_waitrequest |=> !req || avs_waitrequest)
    else $error("Waitrequest low for more than one cycle.");

  irq_clear_a: assert property (
    gated == '0 |=> !uart_irq)
    else $error("Interrupt raised with no enabled flag.");

  // Per-event gating: a lone flag raises the interrupt only if enabled.
  // cts gate check
  cts_gate_a: assert property (
    evt_flags[UEI_BIT_CTS] && solo_evt[UEI_BIT_CTS]
    |=> uart_irq == $past(st_q.en[UEI_BIT_CTS]))
    else $error("Clear-to-send enable does not gate its interrupt.");

  cts_off_gate_a: assert property (
    evt_flags[UEI_BIT_CTS_OFF] && solo_evt[UEI_BIT_CTS_OFF]
    |=> uart_irq == $past(st_q.en[UEI_BIT_CTS_OFF]))
    else $error("Clear-to-send-off enable does not gate its interrupt.");

  rx_ready_gate_a: assert property (
    evt_flags[UEI_BIT_RXRDY] && solo_evt[UEI_BIT_RXRDY]
    |=> uart_irq == $past(st_q.en[UEI_BIT_RXRDY]))
    else $error("Received-byte enable does not gate its interrupt.");

  rx_end_gate_a: assert property (
    evt_flags[UEI_BIT_RXEND] && solo_evt[UEI_BIT_RXEND]
    |=> uart_irq == $past(st_q.en[UEI_BIT_RXEND]))
    else $error("Receive-buffer-end enable does not gate its interrupt.");

  tx_sent_gate_a: assert property (
    evt_flags[UEI_BIT_TXSENT] && solo_evt[UEI_BIT_TXSENT]
    |=> uart_irq == $past(st_q.en[UEI_BIT_TXSENT]))
    else $error("Transmitted-byte enable does not gate its interrupt.");

  tx_end_gate_a: assert property (
    evt_flags[UEI_BIT_TXEND] && solo_evt[UEI_BIT_TXEND]
    |=> uart_irq == $past(st_q.en[UEI_BIT_TXEND]))
    else $error("Transmit-buffer-end enable does not gate its interrupt.");

  error_gate_a: assert property (
    evt_flags[UEI_BIT_ERROR] && solo_evt[UEI_BIT_ERROR]
    |=> uart_irq == $past(st_q.en[UEI_BIT_ERROR]))
    else $error("Error enable does not gate its interrupt.");

  rx_tmo_gate_a: assert property (
    evt_flags[UEI_BIT_RX_TIMEOUT] && solo_evt[UEI_BIT_RX_TIMEOUT]
    |=> uart_irq == $past(st_q.en[UEI_BIT_RX_TIMEOUT]))
    else $error("Receiver-timeout enable does not gate its interrupt.");

  rx_begun_gate_a: assert property (
    evt_flags[UEI_BIT_RXBEGUN] && solo_evt[UEI_BIT_RXBEGUN]
    |=> uart_irq == $past(st_q.en[UEI_BIT_RXBEGUN]))
    else $error("Receiver-started enable does not gate its interrupt.");

  tx_begun_gate_a: assert property (
    evt_flags[UEI_BIT_TXBEGUN] && solo_evt[UEI_BIT_TXBEGUN]
    |=> uart_irq == $past(st_q.en[UEI_BIT_TXBEGUN]))
    else $error("Transmitter-started enable does not gate its interrupt.");

  tx_halt_gate_a: assert property (
    evt_flags[UEI_BIT_TXHALT] && solo_evt[UEI_BIT_TXHALT]
    |=> uart_irq == $past(st_q.en[UEI_BIT_TXHALT]))
    else $error("Transmitter-stopped enable does not gate its interrupt.");

endmodule // uei_top

// >>> testbench/uei_core_model.sv
// Core-side interrupt input: registers the level of uart_irq.
// Assumes the block's clock and reset.
`timescale 1ns/10ps
module uei_core_model (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_b,
  // Interrupt line.
  input wire logic uart_irq,
  output logic irq_seen_q
);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) irq_seen_q <= 1'b0;
    else irq_seen_q <= uart_irq;
  end
endmodule // uei_core_model

// >>> testbench/uart_event_interrupt_enable_tb.sv
// Bench for uei_top: Avalon-MM register tests and event gating.
// Assumes the core model sees uart_irq one cycle late.
`timescale 1ns/10ps
module uart_event_interrupt_enable_tb;
  import uei_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [UEI_ADDR_W-1:0] adr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [UEI_DATA_W-1:0] wdat = '0;
  logic [UEI_BE_W-1:0] be = 4'hf;
  logic [UEI_DATA_W-1:0] rdat;
  logic wait_req;
  logic [UEI_NUM_EVT-1:0] flags = '0;
  logic irq;
  logic irq_seen_q;
  int error_cnt = 0;
  int num_checks = 0;
  always #2 clk_sys = ~clk_sys;
  uei_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
    .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wait_req), .evt_flags(flags), .uart_irq(irq));
  uei_core_model core (.clk_sys(clk_sys), .rst_b(rst_b),
    .uart_irq(irq), .irq_seen_q(irq_seen_q));
  task automatic bus(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk_sys); while (wait_req !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk("readdata", q, exp);
  endtask
  task automatic wr32(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic irq_chk(input logic exp);
    repeat (3) @(posedge clk_sys);
    chk("irq", {31'h0, irq_seen_q}, {31'h0, exp});
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    rchk(UEI_ADDR_MASK, 32'h0);
    rchk(UEI_ADDR_SET, 32'h0);
    rchk(UEI_ADDR_CLR, 32'h0);
    $display("reset test done");
    for (int i = 0; i < UEI_NUM_EVT; i++) begin
      wr32(UEI_ADDR_CLR, 32'h7ff);
      flags <= 11'h1 << i;
      irq_chk(1'b0);
      wr32(UEI_ADDR_SET, 32'h1 << i);
      irq_chk(1'b1);
      flags <= ~(11'h1 << i);
      irq_chk(1'b0);
    end
    flags <= '0;
    $display("event gating test done");
    wr32(UEI_ADDR_MASK, 32'h555);
    wr32(UEI_ADDR_SET, 32'h0);
    rchk(UEI_ADDR_SET, 32'h555);
    wr32(UEI_ADDR_SET, 32'h0aa);
    rchk(UEI_ADDR_MASK, 32'h5ff);
    wr32(UEI_ADDR_CLR, 32'h00f);
    rchk(UEI_ADDR_CLR, 32'h5f0);
    rchk(12'h30c, 32'h0);
    wr32(12'h30c, 32'h7ff);
    rchk(UEI_ADDR_MASK, 32'h5f0);
    be <= 4'hc;
    wr32(UEI_ADDR_MASK, 32'h0);
    be <= 4'hf;
    rchk(UEI_ADDR_MASK, 32'h5f0);
    $display("alias test done");
    end_of_test();
  end
endmodule // uart_event_interrupt_enable_tb
